// [iau_pkg.sv]
// package for the dual integer address unit: widths, opcodes, register indexes
// assumes a single core clock; no software-visible registers
package iau_pkg;
   localparam int DATA_W = 32;
   localparam int REG_N = 31;
   localparam int IDX_W = 5;
   localparam int CIRC_N = 4;
   localparam logic [4:0] ZERO_IDX = 5'h1f;
   // base registers at 8..11, length registers at 12..15, loop counter at 30
   localparam logic [4:0] BASE_IDX0 = 5'h08;
   localparam logic [4:0] LEN_IDX0 = 5'h0c;
   localparam logic [4:0] LOOP_IDX = 5'h1e;
   localparam logic [31:0] RESET_VAL = 32'h0;
   typedef enum logic [3:0]
   {
      OP_ADD = 4'h0,
      OP_SUB = 4'h1,
      OP_AND = 4'h2,
      OP_OR = 4'h3,
      OP_XOR = 4'h4,
      OP_MOVI = 4'h5,
      OP_ADDR = 4'h6,
      OP_LOOP = 4'h7
   } iau_op_t;
   typedef enum logic [1:0]
   {
      AM_IMM = 2'h0,
      AM_PRE = 2'h1,
      AM_POST = 2'h2
   } iau_amode_t;
   typedef enum logic [1:0]
   {
      SZ_SINGLE = 2'h0,
      SZ_DUAL = 2'h1,
      SZ_QUAD = 2'h2
   } iau_size_t;
   typedef enum logic [1:0]
   {
      WM_LINEAR = 2'h0,
      WM_CIRC = 2'h1,
      WM_BREV = 2'h2
   } iau_wmode_t;
   typedef enum logic [1:0]
   {
      ST_RUN = 2'h1,
      ST_STALL = 2'h2
   } iau_state_t;
endpackage

// [iau_tb.sv]
// testbench for the dual integer address unit: drives both issue slots directly
// assumes the design's own assertions run alongside; expected values queued per cycle
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {int due; int u; int k; logic [31:0] v; logic [1:0] s;} iau_note_t;
   iau_note_t q[$];
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic v[2], sv[2], busy[2];
   iau_pkg::iau_op_t op[2];
   iau_pkg::iau_amode_t am[2];
   iau_pkg::iau_wmode_t wm[2];
   iau_pkg::iau_size_t sz[2];
   logic [4:0] dst[2], sa[2], sb[2], lidx[2];
   logic [1:0] circ[2];
   logic [31:0] imm[2], a[2], b[2], p[2], nxt, m;
   logic mods_pre;
   logic [31:0] mods[4] = '{32'h2, 32'h2, 32'hfffffffb, 32'h3};
   wire stall;
   wire av[2], nz[2];
   wire [31:0] addr[2], res[2];
   wire iau_pkg::iau_size_t osz[2];
   int cyc = 0;
   int fail_count = 0;
   int compares = 0;
   iau_top u_iau_top (.i_clock(clk), .i_rst_b(rst_b),
      .i_valid0(v[0]), .i_op0(op[0]), .i_amode0(am[0]), .i_wmode0(wm[0]), .i_size0(sz[0]),
      .i_dst0(dst[0]), .i_src_a0(sa[0]), .i_src_b0(sb[0]), .i_circ0(circ[0]), .i_imm0(imm[0]),
      .i_valid1(v[1]), .i_op1(op[1]), .i_amode1(am[1]), .i_wmode1(wm[1]), .i_size1(sz[1]),
      .i_dst1(dst[1]), .i_src_a1(sa[1]), .i_src_b1(sb[1]), .i_circ1(circ[1]), .i_imm1(imm[1]),
      .i_load_busy0(busy[0]), .i_load_idx0(lidx[0]), .i_load_busy1(busy[1]),
      .i_load_idx1(lidx[1]), .o_stall(stall),
      .o_addr_valid0(av[0]), .o_addr0(addr[0]), .o_size0(osz[0]), .o_loop_nz0(nz[0]),
      .o_result0(res[0]), .o_addr_valid1(av[1]), .o_addr1(addr[1]), .o_size1(osz[1]),
      .o_loop_nz1(nz[1]), .o_result1(res[1]));
   always #20 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   function automatic logic [31:0] calc(input int k, input logic [31:0] x, input logic [31:0] y);
      case (k)
         0: return x + y;
         1: return x - y;
         2: return x & y;
         3: return x | y;
         default: return x ^ y;
      endcase
   endfunction
   function automatic logic [31:0] wrap(input logic [31:0] x, input logic [31:0] bs);
      if (x >= bs + 32'hb) return x - 32'hb;
      if (x < bs) return x + 32'hb;
      return x;
   endfunction
   function automatic logic [31:0] rev(input logic [31:0] x);
      logic [31:0] r;
      for (int i = 0; i < 32; i++) r[i] = x[31-i];
      return r;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      // notes never checked count as misses
      fail_count += q.size();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic note(input int u, input int k, input logic [31:0] val, input logic [1:0] s);
      q.push_back('{cyc + 1, u, k, val, s});
   endtask
   task automatic ins(input int u, input iau_pkg::iau_op_t o, input iau_pkg::iau_amode_t md,
      input iau_pkg::iau_wmode_t w, input iau_pkg::iau_size_t s, input logic [4:0] d,
      input logic [4:0] x, input logic [4:0] y, input logic [1:0] c, input logic [31:0] i);
      op[u] = o;
      am[u] = md;
      wm[u] = w;
      sz[u] = s;
      dst[u] = d;
      sa[u] = x;
      sb[u] = y;
      circ[u] = c;
      imm[u] = i;
      sv[u] = 1'b1;
   endtask
   task automatic alu(input int u, input int k, input logic [4:0] d, input logic [4:0] x,
      input logic [4:0] y, input logic [31:0] e);
      // operand b comes from the register file only outside immediate mode
      ins(u, iau_pkg::iau_op_t'(k), iau_pkg::AM_POST, iau_pkg::WM_LINEAR, iau_pkg::SZ_SINGLE,
         d, x, y, 2'h0, 32'h0);
      note(u, 0, e, 2'h0);
   endtask
   task automatic movi(input int u, input logic [4:0] d, input logic [31:0] val);
      ins(u, iau_pkg::OP_MOVI, iau_pkg::AM_IMM, iau_pkg::WM_LINEAR, iau_pkg::SZ_SINGLE,
         d, 5'h1f, 5'h1f, 2'h0, val);
      note(u, 0, val, 2'h0);
   endtask
   task automatic tick();
      v[0] = sv[0];
      v[1] = sv[1];
      sv[0] = 1'b0;
      sv[1] = 1'b0;
      @(posedge clk);
      #2;
   endtask
   // scoreboard: takes the oldest notes due this cycle once outputs have settled
   always @(negedge clk)
   begin
      iau_note_t n;
      while (q.size() > 0 && q[0].due == cyc)
      begin
         n = q.pop_front();
         case (n.k)
            0: chk(res[n.u], n.v);
            1:
            begin
               chk({31'h0, av[n.u]}, 32'h1);
               chk(addr[n.u], n.v);
               chk({30'h0, osz[n.u]}, {30'h0, n.s});
            end
            2: chk({31'h0, stall}, n.v);
            default: chk({31'h0, nz[n.u]}, n.v);
         endcase
      end
   end
   always @(posedge clk)
      if (cyc == 1000)
      begin
         fail_count++;
         wrap_up();
      end
   initial
   begin
      for (int u = 0; u < 2; u++)
      begin
         busy[u] = 1'b0;
         lidx[u] = 5'h0;
         ins(u, iau_pkg::OP_ADD, iau_pkg::AM_IMM, iau_pkg::WM_LINEAR, iau_pkg::SZ_SINGLE,
            5'h1f, 5'h1f, 5'h1f, 2'h0, 32'h0);
      end
      tick();
      void'($urandom(32'hb13e));
      repeat (3) @(posedge clk);
      #2 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      note(0, 0, 32'h0, 2'h0);
      note(1, 0, 32'h0, 2'h0);
      note(0, 2, 32'h0, 2'h0);
      tick();
      // both units load the same indexes with different values, then combine next cycle
      for (int k = 0; k < 5; k++)
      begin
         for (int u = 0; u < 2; u++) a[u] = $urandom;
         for (int u = 0; u < 2; u++) b[u] = $urandom;
         for (int u = 0; u < 2; u++) movi(u, 5'h1, a[u]);
         tick();
         for (int u = 0; u < 2; u++) movi(u, 5'h2, b[u]);
         tick();
         for (int u = 0; u < 2; u++) alu(u, k, 5'h3, 5'h1, 5'h2, calc(k, a[u], b[u]));
         tick();
      end
      // circular buffer at an unaligned base, odd length, unit u uses buffer u+1
      for (int u = 0; u < 2; u++) movi(u, iau_pkg::BASE_IDX0 + 5'(u + 1), 32'h103 + 32'(u * 64));
      tick();
      for (int u = 0; u < 2; u++) movi(u, iau_pkg::LEN_IDX0 + 5'(u + 1), 32'hb);
      tick();
      for (int u = 0; u < 2; u++) p[u] = 32'h10c + 32'(u * 64);
      for (int u = 0; u < 2; u++) movi(u, 5'h3, p[u]);
      tick();
      for (int k = 0; k < 4; k++)
      begin
         // the pointer modifier travels in a register, not the immediate
         for (int u = 0; u < 2; u++) movi(u, 5'h10, mods[k]);
         tick();
         mods_pre = (k >= 2);
         for (int u = 0; u < 2; u++)
         begin
            nxt = wrap(p[u] + mods[k], 32'h103 + 32'(u * 64));
            ins(u, iau_pkg::OP_ADDR, mods_pre ? iau_pkg::AM_PRE : iau_pkg::AM_POST,
               iau_pkg::WM_CIRC, iau_pkg::iau_size_t'(k % 3), 5'h1f, 5'h3, 5'h10, 2'(u + 1), mods[k]);
            note(u, 1, mods_pre ? nxt : p[u], 2'(k % 3));
            p[u] = nxt;
         end
         tick();
      end
      for (int u = 0; u < 2; u++) alu(u, 0, 5'h4, 5'h3, 5'h1f, p[u]);
      tick();
      for (int u = 0; u < 2; u++) movi(u, 5'h5, 32'h0);
      for (int u = 0; u < 2; u++) p[u] = 32'h0;
      tick();
      for (int u = 0; u < 2; u++) movi(u, 5'h10, 32'h80000000 >> u);
      tick();
      for (int k = 0; k < 4; k++)
      begin
         for (int u = 0; u < 2; u++)
         begin
            m = 32'h80000000 >> u;
            ins(u, iau_pkg::OP_ADDR, iau_pkg::AM_POST, iau_pkg::WM_BREV, iau_pkg::SZ_DUAL,
               5'h1f, 5'h5, 5'h10, 2'h0, m);
            note(u, 1, p[u], 2'h1);
            p[u] = rev(rev(p[u]) + rev(m));
         end
         tick();
      end
      for (int u = 0; u < 2; u++)
      begin
         m = $urandom;
         ins(u, iau_pkg::OP_ADDR, iau_pkg::AM_IMM, iau_pkg::WM_LINEAR, iau_pkg::SZ_QUAD,
            5'h1f, 5'h1f, 5'h1f, 2'h0, m);
         note(u, 1, m, 2'h2);
      end
      tick();
      for (int u = 0; u < 2; u++) movi(u, iau_pkg::LOOP_IDX, 32'h2);
      tick();
      for (int k = 0; k < 2; k++)
      begin
         for (int u = 0; u < 2; u++)
         begin
            ins(u, iau_pkg::OP_LOOP, iau_pkg::AM_IMM, iau_pkg::WM_LINEAR, iau_pkg::SZ_SINGLE,
               iau_pkg::LOOP_IDX, iau_pkg::LOOP_IDX, 5'h1f, 2'h0, 32'h0);
            note(u, 3, (k == 0) ? 32'h1 : 32'h0, 2'h0);
         end
         tick();
      end
      for (int u = 0; u < 2; u++) movi(u, 5'h10, 32'h4);
      tick();
      // pending load into the pointer refuses the whole line, then it is re-presented
      busy[0] = 1'b1;
      lidx[0] = 5'h1;
      ins(0, iau_pkg::OP_ADDR, iau_pkg::AM_POST, iau_pkg::WM_LINEAR, iau_pkg::SZ_DUAL,
         5'h1f, 5'h1, 5'h10, 2'h0, 32'h4);
      note(0, 2, 32'h1, 2'h0);
      tick();
      busy[0] = 1'b0;
      busy[1] = 1'b1;
      lidx[1] = 5'h9;
      ins(0, iau_pkg::OP_ADDR, iau_pkg::AM_POST, iau_pkg::WM_LINEAR, iau_pkg::SZ_DUAL,
         5'h1f, 5'h1, 5'h10, 2'h0, 32'h4);
      note(0, 1, a[0], 2'h1);
      note(0, 2, 32'h0, 2'h0);
      alu(1, 0, 5'h6, 5'h1, 5'h2, a[1] + b[1]);
      tick();
      busy[1] = 1'b0;
      alu(0, 0, 5'h6, 5'h1, 5'h1f, a[0] + 32'h4);
      tick();
      tick();
      wrap_up();
   end
endmodule
`default_nettype wire

// [iau_top.sv]
// dual integer address unit top: reset sync, dependency checker, two units
// assumes issue side is on the core clock; the issuer holds an instruction while stalled
`timescale 1ns/1ps
`default_nettype none
module iau_top #(
   parameter int DATA_W = iau_pkg::DATA_W
)(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   // issue slot, unit 0
   input wire logic i_valid0,
   input wire iau_pkg::iau_op_t i_op0,
   input wire iau_pkg::iau_amode_t i_amode0,
   input wire iau_pkg::iau_wmode_t i_wmode0,
   input wire iau_pkg::iau_size_t i_size0,
   input wire logic [iau_pkg::IDX_W-1:0] i_dst0,
   input wire logic [iau_pkg::IDX_W-1:0] i_src_a0,
   input wire logic [iau_pkg::IDX_W-1:0] i_src_b0,
   input wire logic [1:0] i_circ0,
   input wire logic [DATA_W-1:0] i_imm0,
   // issue slot, unit 1
   input wire logic i_valid1,
   input wire iau_pkg::iau_op_t i_op1,
   input wire iau_pkg::iau_amode_t i_amode1,
   input wire iau_pkg::iau_wmode_t i_wmode1,
   input wire iau_pkg::iau_size_t i_size1,
   input wire logic [iau_pkg::IDX_W-1:0] i_dst1,
   input wire logic [iau_pkg::IDX_W-1:0] i_src_a1,
   input wire logic [iau_pkg::IDX_W-1:0] i_src_b1,
   input wire logic [1:0] i_circ1,
   input wire logic [DATA_W-1:0] i_imm1,
   // external result dependency: a memory load still pending into a unit register
   input wire logic i_load_busy0,
   input wire logic [iau_pkg::IDX_W-1:0] i_load_idx0,
   input wire logic i_load_busy1,
   input wire logic [iau_pkg::IDX_W-1:0] i_load_idx1,
   // outputs
   output logic o_stall,
   output logic o_addr_valid0,
   output logic [DATA_W-1:0] o_addr0,
   output iau_pkg::iau_size_t o_size0,
   output logic o_loop_nz0,
   output logic [DATA_W-1:0] o_result0,
   output logic o_addr_valid1,
   output logic [DATA_W-1:0] o_addr1,
   output iau_pkg::iau_size_t o_size1,
   output logic o_loop_nz1,
   output logic [DATA_W-1:0] o_result1
);
   logic rst_meta, rst_b;
   logic hazard0, hazard1, hazard;
   iau_pkg::iau_state_t state, next_state;

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rst_meta <= 1'b0;
         rst_b <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_b <= rst_meta;
      end
   end

   // a source waiting on a pending load is unavailable this cycle
   always_comb
   begin
      hazard0 = i_valid0 && i_load_busy0 && i_load_idx0 != iau_pkg::ZERO_IDX &&
                (i_load_idx0 == i_src_a0 || i_load_idx0 == i_src_b0);
      hazard1 = i_valid1 && i_load_busy1 && i_load_idx1 != iau_pkg::ZERO_IDX &&
                (i_load_idx1 == i_src_a1 || i_load_idx1 == i_src_b1);
      hazard = hazard0 || hazard1;
      next_state = hazard ? iau_pkg::ST_STALL : iau_pkg::ST_RUN;
   end

   always_ff @(posedge i_clock or negedge rst_b)
   begin
      if (!rst_b)
         state <= iau_pkg::ST_RUN;
      else
         state <= next_state;
   end

   always_comb
   begin
      case (state)
         iau_pkg::ST_STALL: o_stall = 1'b1;
         default: o_stall = 1'b0;
      endcase
   end

   // both units halt together so the issue line stays in lockstep
   iau_unit #(.DATA_W(DATA_W)) u_unit0 (
      .i_clock(i_clock), .i_rst_b(rst_b), .i_valid(i_valid0 && !hazard),
      .i_op(i_op0), .i_amode(i_amode0), .i_wmode(i_wmode0), .i_size(i_size0),
      .i_dst(i_dst0), .i_src_a(i_src_a0), .i_src_b(i_src_b0), .i_circ(i_circ0),
      .i_imm(i_imm0), .o_addr_valid(o_addr_valid0), .o_addr(o_addr0),
      .o_size(o_size0), .o_loop_nz(o_loop_nz0), .o_result(o_result0)
   );
   iau_unit #(.DATA_W(DATA_W)) u_unit1 (
      .i_clock(i_clock), .i_rst_b(rst_b), .i_valid(i_valid1 && !hazard),
      .i_op(i_op1), .i_amode(i_amode1), .i_wmode(i_wmode1), .i_size(i_size1),
      .i_dst(i_dst1), .i_src_a(i_src_a1), .i_src_b(i_src_b1), .i_circ(i_circ1),
      .i_imm(i_imm1), .o_addr_valid(o_addr_valid1), .o_addr(o_addr1),
      .o_size(o_size1), .o_loop_nz(o_loop_nz1), .o_result(o_result1)
   );

   AST_STALL_ON_HAZARD: assert property (@(posedge i_clock) disable iff (!rst_b)
      hazard |=> o_stall) else $error("hazard did not stall");
   AST_NO_STALL_CLEAN: assert property (@(posedge i_clock) disable iff (!rst_b)
      !hazard |=> !o_stall) else $error("spurious stall");
   AST_ADDR_ONE_CYCLE: assert property (@(posedge i_clock) disable iff (!rst_b)
      (i_valid0 && !hazard && i_op0 == iau_pkg::OP_ADDR) |=> o_addr_valid0)
      else $error("address not produced next cycle");
   AST_ADDR_ONLY_ISSUED: assert property (@(posedge i_clock) disable iff (!rst_b)
      !(i_valid1 && !hazard && i_op1 == iau_pkg::OP_ADDR) |=> !o_addr_valid1)
      else $error("address without issue");
   AST_SIZE_PASSED: assert property (@(posedge i_clock) disable iff (!rst_b)
      (i_valid0 && !hazard && i_op0 == iau_pkg::OP_ADDR) |=> o_size0 == $past(i_size0))
      else $error("access size lost");
   AST_IMM_ADDR: assert property (@(posedge i_clock) disable iff (!rst_b)
      (i_valid1 && !hazard && i_op1 == iau_pkg::OP_ADDR && i_amode1 == iau_pkg::AM_IMM)
      |=> o_addr1 == $past(i_imm1)) else $error("immediate address wrong");
   AST_MOVI_RESULT: assert property (@(posedge i_clock) disable iff (!rst_b)
      (i_valid0 && !hazard && i_op0 == iau_pkg::OP_MOVI) |=> o_result0 == $past(i_imm0))
      else $error("integer result wrong");
   AST_HOLD_WHEN_STALL: assert property (@(posedge i_clock) disable iff (!rst_b)
      hazard |=> $stable(o_result0) && $stable(o_result1))
      else $error("result changed while stalled");

   COV_STALL: cover property (@(posedge i_clock) disable iff (!rst_b) hazard ##1 !hazard);
   COV_ADDR_BOTH: cover property (@(posedge i_clock) disable iff (!rst_b)
      o_addr_valid0 && o_addr_valid1);
   COV_LOOP: cover property (@(posedge i_clock) disable iff (!rst_b) o_loop_nz0);
endmodule
`default_nettype wire

// [iau_unit.sv]
// one integer address unit: register file, integer alu, address generator
// assumes an active-low reset that the top already releases in step with the clock
`timescale 1ns/1ps
`default_nettype none
module iau_unit #(
   parameter int DATA_W = iau_pkg::DATA_W
)(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   // issued instruction
   input wire logic i_valid,
   input wire iau_pkg::iau_op_t i_op,
   input wire iau_pkg::iau_amode_t i_amode,
   input wire iau_pkg::iau_wmode_t i_wmode,
   input wire iau_pkg::iau_size_t i_size,
   input wire logic [iau_pkg::IDX_W-1:0] i_dst,
   input wire logic [iau_pkg::IDX_W-1:0] i_src_a,
   input wire logic [iau_pkg::IDX_W-1:0] i_src_b,
   input wire logic [1:0] i_circ,
   input wire logic [DATA_W-1:0] i_imm,
   // results
   output logic o_addr_valid,
   output logic [DATA_W-1:0] o_addr,
   output iau_pkg::iau_size_t o_size,
   output logic o_loop_nz,
   output logic [DATA_W-1:0] o_result
);
   logic [DATA_W-1:0] rf [iau_pkg::REG_N];
   logic [DATA_W-1:0] next_rf [iau_pkg::REG_N];
   logic [DATA_W-1:0] next_addr;
   logic [DATA_W-1:0] next_result;
   logic next_addr_valid;
   logic next_loop_nz;
   iau_pkg::iau_size_t next_size;

   function automatic logic [DATA_W-1:0] rd(input logic [iau_pkg::IDX_W-1:0] idx,
                                           input logic [DATA_W-1:0] f [iau_pkg::REG_N]);
      rd = (idx == iau_pkg::ZERO_IDX) ? '0 : f[idx];
   endfunction

   function automatic logic [DATA_W-1:0] rev(input logic [DATA_W-1:0] v);
      for (int k = 0; k < DATA_W; k++)
      begin
         rev[k] = v[DATA_W-1-k];
      end
   endfunction

   always_comb
   begin
      logic [DATA_W-1:0] a, b, base, len, endp, sum, upd;
      logic [iau_pkg::IDX_W-1:0] bi, li;
      a = rd(i_src_a, rf);
      b = (i_amode == iau_pkg::AM_IMM) ? i_imm : rd(i_src_b, rf);
      bi = iau_pkg::BASE_IDX0 + {3'h0, i_circ};
      li = iau_pkg::LEN_IDX0 + {3'h0, i_circ};
      base = rf[bi];
      len = rf[li];
      endp = base + len;
      sum = a + b;
      upd = sum;
      next_rf = rf;
      next_addr = o_addr;
      next_addr_valid = 1'b0;
      next_size = o_size;
      next_result = o_result;
      next_loop_nz = o_loop_nz;
      case (i_wmode)
         iau_pkg::WM_CIRC:
         begin
            // full-width compare, so any base and length work unless base plus len overflows DATA_W bits
            if (sum >= endp)
               upd = sum - len;
            else if (sum < base)
               upd = sum + len;
         end
         iau_pkg::WM_BREV:
            upd = rev(rev(a) + rev(b));
         default:
            upd = sum;
      endcase
      if (i_valid)
      begin
         case (i_op)
            iau_pkg::OP_ADD: next_result = a + b;
            iau_pkg::OP_SUB: next_result = a - b;
            iau_pkg::OP_AND: next_result = a & b;
            iau_pkg::OP_OR: next_result = a | b;
            iau_pkg::OP_XOR: next_result = a ^ b;
            iau_pkg::OP_MOVI: next_result = i_imm;
            iau_pkg::OP_LOOP:
            begin
               // counter decrement; flag tells sequencer to branch back
               next_result = rd(iau_pkg::LOOP_IDX, rf) - DATA_W'(1);
               next_loop_nz = (next_result != '0);
            end
            iau_pkg::OP_ADDR:
            begin
               next_addr_valid = 1'b1;
               next_size = i_size;
               case (i_amode)
                  iau_pkg::AM_IMM: next_addr = i_imm;
                  iau_pkg::AM_PRE: next_addr = upd;
                  default: next_addr = a;
               endcase
               next_result = upd;
            end
            default: next_result = o_result;
         endcase
         if (i_op == iau_pkg::OP_LOOP)
            next_rf[iau_pkg::LOOP_IDX] = next_result;
         else if (i_op == iau_pkg::OP_ADDR && i_amode != iau_pkg::AM_IMM &&
                  i_src_a != iau_pkg::ZERO_IDX)
            next_rf[i_src_a] = upd; // pointer write-back
         else if (i_op != iau_pkg::OP_ADDR && i_dst != iau_pkg::ZERO_IDX)
            next_rf[i_dst] = next_result;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         for (int k = 0; k < iau_pkg::REG_N; k++)
            rf[k] <= DATA_W'(iau_pkg::RESET_VAL);
         o_addr <= DATA_W'(iau_pkg::RESET_VAL);
         o_result <= DATA_W'(iau_pkg::RESET_VAL);
         o_addr_valid <= 1'b0;
         o_loop_nz <= 1'b0;
         o_size <= iau_pkg::SZ_SINGLE;
      end
      else
      begin
         rf <= next_rf;
         o_addr <= next_addr;
         o_result <= next_result;
         o_addr_valid <= next_addr_valid;
         o_loop_nz <= next_loop_nz;
         o_size <= next_size;
      end
   end
endmodule
`default_nettype wire
